/* src/dtc_timer_top.sv */
// Chosen here: the address map and the Wishbone interface to the registers.
`default_nettype none
module dtc_timer_top (
  input wire logic mclk,
  input wire logic rst,
  input wire dtc_pkg::dtc_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_a_event_input_pin,
  input wire logic timer_b_event_input_pin,
  output logic timer_a_out,
  output logic timer_b_out,
  output logic timer_match_interrupt
);
  import dtc_pkg::*;

  typedef struct packed {
    dtc_bus_t bus;
    logic ack;
    logic [31:0] dat;
    dtc_ctrl_t timer_a_control;
    dtc_ctrl_t timer_b_control;
    logic [7:0] timer_a_period;
    logic [7:0] timer_a_pulse_width;
    logic [7:0] timer_b_period;
    logic [7:0] timer_b_pulse_width;
    logic [7:0] a_pw_act;
    logic [7:0] b_pw_act;
    logic [7:0] a_cnt;
    logic [7:0] b_cnt;
    logic a_flop;
    logic b_flop;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
  } dtc_top_state_t;

  dtc_top_state_t st_reg;
  dtc_top_state_t st_next;
  dtc_taps_t taps;
  logic tick_a;
  logic tick_b;
  logic cascade;
  logic [2:0] mode_a8;
  logic [2:0] mode_b8;
  dtc_step_t step_a;
  dtc_step_t step_b;
  dtc_step_t step_16;
  logic [1:0] hits;
  logic bus_take;
  logic bus_wr;
  logic [1:0] irq_clear;
  logic [31:0] rd_data;

  // shared prescaler, one source mux per timer
  dtc_prescaler u_pre (
    .mclk(mclk),
    .rst(rst),
    .taps(taps)
  );

  dtc_tick_sel u_sel_a (
    .mclk(mclk),
    .rst(rst),
    .taps(taps),
    .clock_select(st_reg.timer_a_control.clock_select),
    .event_pin(timer_a_event_input_pin),
    .tick(tick_a)
  );

  dtc_tick_sel u_sel_b (
    .mclk(mclk),
    .rst(rst),
    .taps(taps),
    .clock_select(st_reg.timer_b_control.clock_select),
    .event_pin(timer_b_event_input_pin),
    .tick(tick_b)
  );

  // one counting step for any width; top masks the count to 8 or 16 bits
  function automatic dtc_step_t dtc_step(
    input logic run,
    input logic [2:0] mode,
    input logic preset,
    input logic [15:0] cnt,
    input logic [15:0] period,
    input logic [15:0] pw_reg,
    input logic [15:0] pw_act,
    input logic flop,
    input logic tick,
    input logic [15:0] top
  );
    dtc_step_t r;
    logic [15:0] nxt;
    r.cnt = cnt;
    r.flop = flop;
    r.pw_act = pw_act;
    r.hit = 1'b0;
    nxt = (cnt + 16'h0001) & top;
    if (!run) begin
      r.cnt = '0;
      r.flop = preset;
      r.pw_act = pw_reg;
    end else begin
      // outside pwm the width is used as written, so it must stay put while running
      if (mode != MODE_PWM8 && mode != MODE_PWM16) begin
        r.pw_act = pw_reg;
      end
      if (tick) begin
        case (mode)
          MODE_TIMER, MODE_T16, MODE_WARM: begin
            if (nxt == period) begin
              r.cnt = '0;
              r.hit = 1'b1;
            end else begin
              r.cnt = nxt;
            end
          end
          MODE_PDO: begin
            if (nxt == period) begin
              r.cnt = '0;
              r.flop = ~flop;
              r.hit = 1'b1;
            end else begin
              r.cnt = nxt;
            end
          end
          MODE_PWM8, MODE_PWM16: begin
            r.cnt = nxt;
            if (nxt == pw_act) begin
              r.flop = ~flop;
            end
            // new width is taken only at wrap, which is what makes running rewrites safe
            if (cnt == top) begin
              r.flop = preset;
              r.pw_act = pw_reg;
              r.hit = 1'b1;
            end
          end
          MODE_PPG: begin
            if (nxt == period) begin
              r.cnt = '0;
              r.flop = preset;
              r.hit = 1'b1;
            end else begin
              r.cnt = nxt;
              if (nxt == pw_act) begin
                r.flop = ~flop;
              end
            end
          end
          default: begin
            r.cnt = cnt;
          end
        endcase
      end
    end
    return r;
  endfunction

  // counting for both timers, separate or cascaded
  always_comb begin
    cascade = st_reg.timer_a_control.mode_select == MODE_CASCADE;
    // 16-bit codes are meaningless on a lone 8-bit timer; the hold code parks it
    mode_a8 = st_reg.timer_a_control.mode_select[2] ? MODE_CASCADE : st_reg.timer_a_control.mode_select;
    mode_b8 = st_reg.timer_b_control.mode_select[2] ? MODE_CASCADE : st_reg.timer_b_control.mode_select;
    step_a = dtc_step(st_reg.timer_a_control.run, mode_a8, st_reg.timer_a_control.out_flop_preset,
                      {8'h00, st_reg.a_cnt}, {8'h00, st_reg.timer_a_period},
                      {8'h00, st_reg.timer_a_pulse_width}, {8'h00, st_reg.a_pw_act},
                      st_reg.a_flop, tick_a, TOP8);
    step_b = dtc_step(st_reg.timer_b_control.run, mode_b8, st_reg.timer_b_control.out_flop_preset,
                      {8'h00, st_reg.b_cnt}, {8'h00, st_reg.timer_b_period},
                      {8'h00, st_reg.timer_b_pulse_width}, {8'h00, st_reg.b_pw_act},
                      st_reg.b_flop, tick_b, TOP8);
    step_16 = dtc_step(st_reg.timer_b_control.run, st_reg.timer_b_control.mode_select,
                       st_reg.timer_b_control.out_flop_preset,
                       {st_reg.b_cnt, st_reg.a_cnt},
                       {st_reg.timer_b_period, st_reg.timer_a_period},
                       {st_reg.timer_b_pulse_width, st_reg.timer_a_pulse_width},
                       {st_reg.b_pw_act, st_reg.a_pw_act},
                       st_reg.b_flop, tick_a, TOP16);
  end

  // bus decode and read mux
  always_comb begin
    bus_take = (st_reg.bus == BUS_IDLE) && wb_req.cyc && wb_req.stb;
    bus_wr = bus_take && wb_req.we && wb_req.sel[0];
    irq_clear = (bus_wr && wb_req.adr == OFF_IRQ_STATUS) ? wb_req.dat[1:0] : 2'h0;
    case (wb_req.adr)
      OFF_A_PERIOD: rd_data = {24'h000000, st_reg.timer_a_period};
      OFF_A_PW: rd_data = {24'h000000, st_reg.timer_a_pulse_width};
      OFF_A_CTRL: rd_data = {24'h000000, st_reg.timer_a_control};
      OFF_B_PERIOD: rd_data = {24'h000000, st_reg.timer_b_period};
      OFF_B_PW: rd_data = {24'h000000, st_reg.timer_b_pulse_width};
      OFF_B_CTRL: rd_data = {24'h000000, st_reg.timer_b_control};
      OFF_IRQ_STATUS: rd_data = {30'h0, st_reg.irq_status};
      OFF_IRQ_MASK: rd_data = {30'h0, st_reg.irq_mask};
      OFF_COUNT: rd_data = {14'h0, st_reg.b_flop, st_reg.a_flop, st_reg.b_cnt, st_reg.a_cnt};
      default: rd_data = 32'h00000000;
    endcase
  end

  // next state: counters first, then software writes to configuration
  always_comb begin
    st_next = st_reg;
    if (cascade) begin
      st_next.a_cnt = step_16.cnt[7:0];
      st_next.b_cnt = step_16.cnt[15:8];
      st_next.a_pw_act = step_16.pw_act[7:0];
      st_next.b_pw_act = step_16.pw_act[15:8];
      st_next.a_flop = st_reg.timer_a_control.out_flop_preset;
      st_next.b_flop = step_16.flop;
      hits = {step_16.hit, 1'b0};
    end else begin
      st_next.a_cnt = step_a.cnt[7:0];
      st_next.b_cnt = step_b.cnt[7:0];
      st_next.a_pw_act = step_a.pw_act[7:0];
      st_next.b_pw_act = step_b.pw_act[7:0];
      st_next.a_flop = step_a.flop;
      st_next.b_flop = step_b.flop;
      hits = {step_b.hit, step_a.hit};
    end
    // a hit in the same cycle as a write-one clear survives
    st_next.irq_status = (st_reg.irq_status & ~irq_clear) | hits;
    // classic wishbone: ack for one cycle, then a forced idle cycle
    case (st_reg.bus)
      BUS_IDLE: begin
        if (bus_take) begin
          st_next.bus = BUS_ACK;
          st_next.ack = 1'b1;
          st_next.dat = wb_req.we ? 32'h00000000 : rd_data;
        end
      end
      BUS_ACK: begin
        st_next.bus = BUS_IDLE;
        st_next.ack = 1'b0;
        st_next.dat = 32'h00000000;
      end
      default: begin
        st_next.bus = BUS_IDLE;
        st_next.ack = 1'b0;
      end
    endcase
    // register writes; a control write applies mode, clock and preset with the start
    if (bus_wr) begin
      case (wb_req.adr)
        OFF_A_PERIOD: st_next.timer_a_period = wb_req.dat[7:0];
        OFF_A_PW: st_next.timer_a_pulse_width = wb_req.dat[7:0];
        OFF_A_CTRL: st_next.timer_a_control = wb_req.dat[7:0];
        OFF_B_PERIOD: st_next.timer_b_period = wb_req.dat[7:0];
        OFF_B_PW: st_next.timer_b_pulse_width = wb_req.dat[7:0];
        OFF_B_CTRL: st_next.timer_b_control = wb_req.dat[7:0];
        OFF_IRQ_MASK: st_next.irq_mask = wb_req.dat[1:0];
        default: st_next.dat = st_next.dat;
      endcase
    end
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '{bus: BUS_IDLE, ack: 1'b0, dat: '0,
                  timer_a_control: CTRL_RESET, timer_b_control: CTRL_RESET,
                  timer_a_period: REG8_RESET, timer_a_pulse_width: REG8_RESET,
                  timer_b_period: REG8_RESET, timer_b_pulse_width: REG8_RESET,
                  a_pw_act: REG8_RESET, b_pw_act: REG8_RESET, a_cnt: REG8_RESET, b_cnt: REG8_RESET,
                  a_flop: 1'b0, b_flop: 1'b0, irq_status: IRQ_RESET, irq_mask: IRQ_RESET, irq: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // all outputs straight from the state register
  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign timer_a_out = st_reg.a_flop;
  assign timer_b_out = st_reg.b_flop;
  assign timer_match_interrupt = st_reg.irq;

  // checks on the running block
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic [2:0] a_ck;
  logic [15:0] cnt16;
  logic [15:0] per16;
  logic [15:0] pw16;
  assign a_ck = st_reg.timer_a_control.clock_select;
  assign cnt16 = {st_reg.b_cnt, st_reg.a_cnt};
  assign per16 = {st_reg.timer_b_period, st_reg.timer_a_period};
  assign pw16 = {st_reg.timer_b_pulse_width, st_reg.timer_a_pulse_width};

  sequence div3_hold;
    (a_ck == CK_DIV3) [*8];
  endsequence

  sequence a_timer_match;
    !cascade && st_reg.timer_a_control.run && st_reg.timer_a_control.mode_select == MODE_TIMER
      && tick_a && (st_reg.a_cnt + 8'h01 == st_reg.timer_a_period);
  endsequence

  sequence a_pdo_match;
    !cascade && st_reg.timer_a_control.run && st_reg.timer_a_control.mode_select == MODE_PDO
      && tick_a && (st_reg.a_cnt + 8'h01 == st_reg.timer_a_period);
  endsequence

  sequence c16_run;
    cascade && st_reg.timer_b_control.run && tick_a;
  endsequence

  div_tick_a: assert property ((tick_a && a_ck == CK_DIV3) ##1 div3_hold |-> tick_a && !$past(tick_a))
    else $error("divide by 8 tick spacing wrong");
  fc_tick_a: assert property (a_ck == CK_FC |-> tick_a)
    else $error("undivided clock does not tick every cycle");
  rsvd_tick_a: assert property (a_ck == CK_RSVD |-> !tick_a)
    else $error("reserved clock code produced a tick");
  stop_clear_a: assert property (($fell(st_reg.timer_a_control.run) && !cascade) |=> st_reg.a_cnt == 8'h00)
    else $error("stopping timer a did not clear its counter");
  preset_flop_a: assert property ((!cascade && !st_reg.timer_a_control.run) ##1 !cascade
      |-> st_reg.a_flop == $past(st_reg.timer_a_control.out_flop_preset))
    else $error("output flop does not follow preset while stopped");
  match_irq_a: assert property (a_timer_match |=> st_reg.a_cnt == 8'h00 && st_reg.irq_status[IRQ_A])
    else $error("period match did not clear and flag timer a");
  pdo_toggle_a: assert property (a_pdo_match |=> st_reg.a_flop != $past(st_reg.a_flop))
    else $error("divider output did not toggle on match");
  event_count_a: assert property ((!$past(rst) && !cascade && st_reg.timer_a_control.run
      && st_reg.timer_a_control.mode_select == MODE_TIMER && a_ck == CK_PIN
      && $past(timer_a_event_input_pin) && !timer_a_event_input_pin
      && (st_reg.a_cnt + 8'h01 != st_reg.timer_a_period))
      |=> st_reg.a_cnt == $past(st_reg.a_cnt) + 8'h01)
    else $error("falling pin edge not counted");
  carry_16_a: assert property ((c16_run and (st_reg.timer_b_control.mode_select == MODE_T16
      && st_reg.a_cnt == TOP8[7:0] && (cnt16 + 16'h0001 != per16)))
      |=> st_reg.b_cnt == $past(st_reg.b_cnt) + 8'h01 && st_reg.a_cnt == 8'h00)
    else $error("cascade carry into high byte lost");
  cascade_run_a: assert property ((cascade && !st_reg.timer_b_control.run) ##1 cascade
      |-> cnt16 == 16'h0000 && st_reg.b_flop == $past(st_reg.timer_b_control.out_flop_preset))
    else $error("cascade not held by upper run bit");
  ppg_edge_a: assert property ((c16_run and (st_reg.timer_b_control.mode_select == MODE_PPG
      && (cnt16 + 16'h0001 == pw16) && (cnt16 + 16'h0001 != per16)))
      |=> st_reg.b_flop != $past(st_reg.b_flop))
    else $error("pulse generator missed width match");
  ctrl_start_a: assert property ((bus_wr && wb_req.adr == OFF_A_CTRL)
      |=> st_reg.timer_a_control == $past(wb_req.dat[7:0]) ##1 st_reg.ack == 1'b0)
    else $error("control write not applied whole");
  irq_level_a: assert property (st_reg.irq == |(st_reg.irq_status & st_reg.irq_mask))
    else $error("interrupt output disagrees with status and mask");
  bus_ack_a: assert property (bus_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
endmodule
`default_nettype wire

/* src/dtc_pkg.sv */
// Function
// - clock field picks fc/2^11, /2^7, /2^5, /2^3, reserved, /2, fc, or own pin
// - run bit 0 stops counting and clears the counter; 1 starts counting
// - lower mode codes: 001 divider output, 010 8-bit PWM, 011 16-bit cascade
// - upper mode codes: divider, PWM8, reserved, 16-bit timer, warm-up, PWM16, pulse generation
// - in cascade the source clock comes from the lower clock field
// - in cascade run and flop preset come from the upper timer's bits
// - mode, clock and preset written together with the start take effect at start
// - flop preset bit: 0 clears the output flop, 1 sets it
// - each timer has a control, a period and a pulse-width register of 8 bits
// - timer mode counts internal ticks; period match raises interrupt and clears counter
// - event mode counts falling pin edges with identical match behaviour
`default_nettype none
package dtc_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [7:0] OFF_A_PERIOD = 8'h00;
  localparam logic [7:0] OFF_A_PW = 8'h04;
  localparam logic [7:0] OFF_A_CTRL = 8'h08;
  localparam logic [7:0] OFF_B_PERIOD = 8'h0c;
  localparam logic [7:0] OFF_B_PW = 8'h10;
  localparam logic [7:0] OFF_B_CTRL = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFF_COUNT = 8'h20;
  // reset values and interrupt status bit numbers
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic PIN_IDLE = 1'b1;
  localparam int unsigned IRQ_A = 0;
  localparam int unsigned IRQ_B = 1;
  // clock select codes
  localparam logic [2:0] CK_DIV11 = 3'h0;
  localparam logic [2:0] CK_DIV7 = 3'h1;
  localparam logic [2:0] CK_DIV5 = 3'h2;
  localparam logic [2:0] CK_DIV3 = 3'h3;
  localparam logic [2:0] CK_RSVD = 3'h4;
  localparam logic [2:0] CK_DIV1 = 3'h5;
  localparam logic [2:0] CK_FC = 3'h6;
  localparam logic [2:0] CK_PIN = 3'h7;
  // mode codes, shared by both control registers
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PDO = 3'h1;
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE_T16 = 3'h4;
  localparam logic [2:0] MODE_WARM = 3'h5;
  localparam logic [2:0] MODE_PWM16 = 3'h6;
  localparam logic [2:0] MODE_PPG = 3'h7;
  // counter ranges and prescaler taps
  localparam logic [15:0] TOP8 = 16'h00ff;
  localparam logic [15:0] TOP16 = 16'hffff;
  localparam int unsigned PRE_W = 11;
  localparam int unsigned TAP11 = 11;
  localparam int unsigned TAP7 = 7;
  localparam int unsigned TAP5 = 5;
  localparam int unsigned TAP3 = 3;
  localparam int unsigned TAP1 = 1;
  typedef struct packed {
    logic out_flop_preset;
    logic [2:0] clock_select;
    logic run;
    logic [2:0] mode_select;
  } dtc_ctrl_t;
  localparam dtc_ctrl_t CTRL_RESET = '0;
  typedef struct packed {
    logic div11;
    logic div7;
    logic div5;
    logic div3;
    logic div1;
    logic div0;
  } dtc_taps_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic flop;
    logic [15:0] pw_act;
    logic hit;
  } dtc_step_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dtc_wb_req_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK = 2'h2
  } dtc_bus_t;
endpackage
`default_nettype wire

/* src/dtc_prescaler.sv */
`default_nettype none
module dtc_prescaler (
  input wire logic mclk,
  input wire logic rst,
  output dtc_pkg::dtc_taps_t taps
);
  import dtc_pkg::*;
  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } dtc_pre_state_t;
  dtc_pre_state_t st_reg;
  dtc_pre_state_t st_next;
  // free-running divider of the system high clock
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + {{(PRE_W-1){1'b0}}, 1'b1};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // one-cycle tap pulses; all-ones low bits give one pulse per 2^k clocks
  always_comb begin
    taps.div11 = &st_reg.cnt[TAP11-1:0];
    taps.div7 = &st_reg.cnt[TAP7-1:0];
    taps.div5 = &st_reg.cnt[TAP5-1:0];
    taps.div3 = &st_reg.cnt[TAP3-1:0];
    taps.div1 = &st_reg.cnt[TAP1-1:0];
    taps.div0 = 1'b1;
  end
endmodule
`default_nettype wire

/* src/dtc_tick_sel.sv */
`default_nettype none
module dtc_tick_sel (
  input wire logic mclk,
  input wire logic rst,
  input wire dtc_pkg::dtc_taps_t taps,
  input wire logic [2:0] clock_select,
  input wire logic event_pin,
  output logic tick
);
  import dtc_pkg::*;
  typedef struct packed {
    logic pin_prev;
  } dtc_sel_state_t;
  dtc_sel_state_t st_reg;
  dtc_sel_state_t st_next;
  // remember the pin so a falling edge becomes one tick
  always_comb begin
    st_next = st_reg;
    st_next.pin_prev = event_pin;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '{pin_prev: PIN_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end
  // source clock mux; the reserved code never ticks so a stray setting freezes the counter
  always_comb begin
    case (clock_select)
      CK_DIV11: tick = taps.div11;
      CK_DIV7: tick = taps.div7;
      CK_DIV5: tick = taps.div5;
      CK_DIV3: tick = taps.div3;
      CK_DIV1: tick = taps.div1;
      CK_FC: tick = taps.div0;
      CK_PIN: tick = st_reg.pin_prev & ~event_pin;
      default: tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* verification/tb_dtc_timer_top.sv */
`default_nettype none
module tb_dtc_timer_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dtc_pkg::*;
  logic mclk;
  logic rst;
  logic pin_a;
  logic pin_b;
  dtc_wb_req_t wb_req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic timer_a_out;
  logic timer_b_out;
  logic timer_match_interrupt;
  int fail_count;
  int n_checks;
  logic [31:0] rd;
  int n;
  dtc_timer_top u_dut (.mclk(mclk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_a_event_input_pin(pin_a), .timer_b_event_input_pin(pin_b), .timer_a_out(timer_a_out),
    .timer_b_out(timer_b_out), .timer_match_interrupt(timer_match_interrupt));
  // 20 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; request held until ack is sampled, then released for a cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_req <= '0;
    if (k >= 20) begin
      fail_count++;
      stop_test();
    end
  endtask
  function automatic logic [31:0] ctl(input logic p, input logic [2:0] ck, input logic r, input logic [2:0] m);
    return {24'h0, p, ck, r, m};
  endfunction
  // cycles until the level interrupt is seen, bounded
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (timer_match_interrupt !== 1'b1 && n < lim);
  endtask
  task automatic t_regs;
    logic [7:0] offs [6];
    offs = '{OFF_A_PERIOD, OFF_A_PW, OFF_A_CTRL, OFF_B_PERIOD, OFF_B_PW, OFF_B_CTRL};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, offs[i], 32'h0);
      check("reset value", rd, {24'h0, REG8_RESET});
      wb(1'b1, offs[i], 32'h52 + i);
      wb(1'b0, offs[i], 32'h0);
      check("register readback", rd, 32'h52 + i);
    end
    wb(1'b0, 8'h24, 32'h0);
    check("unmapped read", rd, 32'h0);
    wb(1'b1, OFF_A_CTRL, 32'h0);
    wb(1'b1, OFF_B_CTRL, 32'h0);
  endtask
  // every mode code lands and reads back while stopped
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_DIV3, 1'b0, m[2:0]));
      wb(1'b0, OFF_B_CTRL, 32'h0);
      check("mode field", rd, ctl(1'b0, CK_DIV3, 1'b0, m[2:0]));
    end
    wb(1'b1, OFF_B_CTRL, 32'h0);
  endtask
  task automatic t_preset;
    wb(1'b1, OFF_A_CTRL, ctl(1'b1, CK_DIV3, 1'b0, MODE_TIMER));
    wb(1'b1, OFF_B_CTRL, ctl(1'b1, CK_DIV3, 1'b0, MODE_TIMER));
    // the flop follows the preset one edge after the control write lands
    @(posedge mclk);
    check("a flop set", timer_a_out, 1'b1);
    check("b flop set", timer_b_out, 1'b1);
    wb(1'b1, OFF_A_CTRL, 32'h0);
    wb(1'b1, OFF_B_CTRL, 32'h0);
    @(posedge mclk);
    check("a flop clear", timer_a_out, 1'b0);
    check("b flop clear", timer_b_out, 1'b0);
  endtask
  // period 2 on each tap: match after about two ticks of the chosen divider
  task automatic t_clocks;
    logic [2:0] cks [6];
    int divs [6];
    cks = '{CK_FC, CK_DIV1, CK_DIV3, CK_DIV5, CK_DIV7, CK_DIV11};
    divs = '{1, 2, 8, 32, 128, 2048};
    wb(1'b1, OFF_IRQ_MASK, 32'h3);
    wb(1'b1, OFF_A_PERIOD, 32'h2);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, OFF_A_CTRL, ctl(1'b0, cks[i], 1'b1, MODE_TIMER));
      wait_irq(3 * divs[i] + 20);
      check("tick spacing", n >= divs[i] && n <= 2 * divs[i] + 1, 1'b1);
      wb(1'b1, OFF_A_CTRL, ctl(1'b0, cks[i], 1'b0, MODE_TIMER));
      wb(1'b0, OFF_COUNT, 32'h0);
      check("count after stop", rd[7:0], 8'h00);
      wb(1'b1, OFF_IRQ_STATUS, 32'h1);
      wb(1'b0, OFF_IRQ_STATUS, 32'h0);
      check("status cleared", rd, 32'h0);
      check("irq low", timer_match_interrupt, 1'b0);
    end
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_RSVD, 1'b1, MODE_TIMER));
    wait_irq(64);
    check("reserved clock idle", timer_match_interrupt, 1'b0);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_RSVD, 1'b0, MODE_TIMER));
    wb(1'b1, OFF_IRQ_MASK, 32'h0);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b1, MODE_TIMER));
    repeat (10) @(posedge mclk);
    wb(1'b0, OFF_IRQ_STATUS, 32'h0);
    check("masked status", rd, 32'h1);
    check("masked irq", timer_match_interrupt, 1'b0);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b0, MODE_TIMER));
    wb(1'b1, OFF_IRQ_MASK, 32'h1);
    check("unmasked irq", timer_match_interrupt, 1'b1);
    wb(1'b1, OFF_IRQ_STATUS, 32'h3);
  endtask
  // falling pin edges are the count source
  task automatic t_event;
    wb(1'b1, OFF_IRQ_MASK, 32'h3);
    wb(1'b1, OFF_A_PERIOD, 32'h3);
    wb(1'b1, OFF_B_PERIOD, 32'h3);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_PIN, 1'b1, MODE_TIMER));
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_PIN, 1'b1, MODE_TIMER));
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, OFF_IRQ_STATUS, 32'h0);
      check("event status", rd, 32'h0);
      @(posedge mclk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (3) @(posedge mclk);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      repeat (3) @(posedge mclk);
    end
    wb(1'b0, OFF_IRQ_STATUS, 32'h0);
    check("event match", rd, 32'h3);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_PIN, 1'b0, MODE_TIMER));
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_PIN, 1'b0, MODE_TIMER));
    wb(1'b1, OFF_IRQ_STATUS, 32'h3);
  endtask
  // 16-bit period 0x0102; lower clock field, upper run bit; upper clock field has no ticks
  task automatic t_cascade;
    wb(1'b1, OFF_A_PERIOD, 32'h2);
    wb(1'b1, OFF_B_PERIOD, 32'h1);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b0, MODE_CASCADE));
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_RSVD, 1'b1, MODE_T16));
    wait_irq(400);
    check("cascade span", n >= 250 && n <= 262, 1'b1);
    wb(1'b0, OFF_IRQ_STATUS, 32'h0);
    check("cascade status", rd, 32'h2);
    check("lower flop holds", timer_a_out, 1'b0);
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_RSVD, 1'b0, MODE_T16));
    wb(1'b0, OFF_COUNT, 32'h0);
    check("cascade cleared", rd[15:0], 16'h0000);
  endtask
  // divider toggles each match; pwm and pulse generator shape the flop; widths set only while stopped
  task automatic t_pulse;
    logic x;
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b1, MODE_PDO));
    @(posedge mclk);
    x = timer_a_out;
    repeat (2) @(posedge mclk);
    check("divider toggle", timer_a_out, !x);
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b0, MODE_PDO));
    wb(1'b1, OFF_B_PW, 32'h40);
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_FC, 1'b1, MODE_PWM8));
    repeat (100) @(posedge mclk);
    check("pwm high", timer_b_out, 1'b1);
    repeat (200) @(posedge mclk);
    check("pwm low after wrap", timer_b_out, 1'b0);
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_FC, 1'b0, MODE_PWM8));
    wb(1'b1, OFF_A_CTRL, ctl(1'b0, CK_FC, 1'b0, MODE_CASCADE));
    wb(1'b1, OFF_A_PW, 32'h80);
    wb(1'b1, OFF_B_PW, 32'h0);
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_RSVD, 1'b1, MODE_PPG));
    repeat (130) @(posedge mclk);
    check("ppg width edge", timer_b_out, 1'b1);
    repeat (130) @(posedge mclk);
    check("ppg period edge", timer_b_out, 1'b0);
    wb(1'b1, OFF_B_CTRL, ctl(1'b0, CK_RSVD, 1'b0, MODE_PPG));
  endtask
  initial begin
    #(40000 * 50);
    fail_count++;
    stop_test();
  end
  initial begin
    fail_count = 0;
    n_checks = 0;
    rst = 1'b1;
    pin_a = PIN_IDLE;
    pin_b = PIN_IDLE;
    wb_req = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_preset();
    t_clocks();
    t_event();
    t_cascade();
    t_pulse();
    stop_test();
  end
endmodule
`default_nettype wire
